// file: hdl/cvsp_vsync_pitch.sv
// vertical sync end, display end, row pitch and vertical interrupt logic
`timescale 1ns/1ps
module cvsp_vsync_pitch #(
  parameter int ADDR_W = 19
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // indexed register port
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // feature status read
  output logic [7:0] feature_status_reg,
  // timing inputs from the rest of the controller
  input wire logic line_start,
  input wire logic [9:0] vertical_total,
  input wire logic [ADDR_W-1:0] screen_start,
  // timing outputs
  output logic [9:0] scanline,
  output logic vsync,
  output logic display_active,
  output logic vblank,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic [2:0] refresh_count,
  // host interrupt
  output logic host_interrupt_pin
);
  // fetch address adder needs room for the 10-bit shifted pitch
  if (ADDR_W < 10 || ADDR_W > 24) begin : g_addr_w_check
    $error("cvsp_vsync_pitch: ADDR_W out of range");
  end

  // host-visible registers
  logic [7:0] hblank_end_r;
  logic [7:0] overflow_r;
  logic [7:0] sync_start_low_r;
  logic [7:0] sync_end_control_r;
  logic [7:0] display_end_low_r;
  logic [7:0] row_pitch_r;
  logic [7:0] vblank_end_r;
  logic [7:0] mode_control_r;
  logic [7:0] extension_overflow_r;
  logic [7:0] reg_rdata_r;
  // timing and status state
  logic [9:0] scanline_r;
  logic vsync_r;
  logic vblank_r;
  logic pending_r;
  logic reg_rvalid_r;
  logic [ADDR_W-1:0] fetch_addr_r;

  // write decode
  wire protect = sync_end_control_r[cvsp_pkg::SEC_PROTECT_BIT];
  wire low_idx = reg_index <= cvsp_pkg::IDX_PROTECT_LAST;
  wire wr_ok = reg_wr && !(protect && low_idx);
  wire wr_hbe = wr_ok && reg_index == cvsp_pkg::IDX_HBLANK_END;
  wire wr_ovf = wr_ok && reg_index == cvsp_pkg::IDX_OVERFLOW;
  wire wr_ovf4 = reg_wr && reg_index == cvsp_pkg::IDX_OVERFLOW;
  wire wr_ss = wr_ok && reg_index == cvsp_pkg::IDX_SYNC_START;
  wire wr_sec = wr_ok && reg_index == cvsp_pkg::IDX_SYNC_END_CTRL;
  wire wr_de = wr_ok && reg_index == cvsp_pkg::IDX_DISP_END_LOW;
  wire wr_rp = wr_ok && reg_index == cvsp_pkg::IDX_ROW_PITCH;
  wire wr_vbe = wr_ok && reg_index == cvsp_pkg::IDX_VBLANK_END;
  wire wr_mode = wr_ok && reg_index == cvsp_pkg::IDX_MODE_CTRL;
  wire wr_ext = wr_ok && reg_index == cvsp_pkg::IDX_EXT_OVERFLOW;

  // overflow: bit 4 always writable, the rest only when unprotected
  logic [7:0] overflow_nxt;
  always_comb begin
    overflow_nxt = overflow_r;
    if (wr_ovf) overflow_nxt = reg_wdata;
    if (wr_ovf4) overflow_nxt[cvsp_pkg::OVF_ALWAYS_BIT] = reg_wdata[cvsp_pkg::OVF_ALWAYS_BIT];
  end

  // read decode; sync-end control hidden unless read enable set
  wire read_en = hblank_end_r[cvsp_pkg::HBE_READ_EN_BIT];
  wire [7:0] rd_mux =
    (reg_index == cvsp_pkg::IDX_HBLANK_END) ? hblank_end_r :
    (reg_index == cvsp_pkg::IDX_OVERFLOW) ? overflow_r :
    (reg_index == cvsp_pkg::IDX_SYNC_START && read_en) ? sync_start_low_r :
    (reg_index == cvsp_pkg::IDX_SYNC_END_CTRL && read_en) ? sync_end_control_r :
    (reg_index == cvsp_pkg::IDX_DISP_END_LOW) ? display_end_low_r :
    (reg_index == cvsp_pkg::IDX_ROW_PITCH) ? row_pitch_r :
    (reg_index == cvsp_pkg::IDX_VBLANK_END) ? vblank_end_r :
    (reg_index == cvsp_pkg::IDX_MODE_CTRL) ? mode_control_r :
    (reg_index == cvsp_pkg::IDX_EXT_OVERFLOW) ? extension_overflow_r :
    8'h00;

  // field assembly
  wire [9:0] sync_start = {overflow_r[cvsp_pkg::OVF_SS9_BIT],
    overflow_r[cvsp_pkg::OVF_SS8_BIT], sync_start_low_r};
  wire [9:0] display_end = {overflow_r[cvsp_pkg::OVF_DE9_BIT],
    overflow_r[cvsp_pkg::OVF_DE8_BIT], display_end_low_r};
  wire [3:0] sync_end = sync_end_control_r[cvsp_pkg::SEC_END_MSB:0];
  wire [8:0] pitch9 = {extension_overflow_r[cvsp_pkg::EXT_PITCH8_BIT], row_pitch_r};
  // byte/word bit set means byte mode: no shift
  wire [9:0] pitch_sh = mode_control_r[cvsp_pkg::MODE_BYTE_WORD_BIT] ?
    {1'b0, pitch9} : {pitch9, 1'b0};

  // scanline sequencing
  wire last_line = scanline_r == vertical_total;
  wire [9:0] scanline_nxt = last_line ? 10'h000 : scanline_r + 10'h001;
  wire [ADDR_W-1:0] fetch_nxt = last_line ? screen_start :
    fetch_addr_r + ADDR_W'(pitch_sh);

  // sync: only 4 counter bits compared, so width wraps at 16 lines; the host
  // must keep end before total or sync spills into the next frame
  wire sync_on = scanline_nxt == sync_start;
  wire sync_off = scanline_nxt[3:0] == sync_end;
  wire vsync_nxt = sync_on ? 1'b1 : (sync_off ? 1'b0 : vsync_r);
  wire vblank_off = scanline_nxt[7:0] == vblank_end_r;
  wire vblank_on = scanline_nxt == display_end;
  wire vblank_nxt = vblank_off ? 1'b0 : (vblank_on ? 1'b1 : vblank_r);

  // pending interrupt: set at display end, held clear while clear bit is 0
  wire irq_clr_n = sync_end_control_r[cvsp_pkg::SEC_IRQ_CLR_BIT];
  wire irq_set = line_start && scanline_nxt == display_end;
  wire pending_nxt = !irq_clr_n ? 1'b0 : (irq_set ? 1'b1 : pending_r);

  // one short block per register keeps each write enable beside its target
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) hblank_end_r <= cvsp_pkg::RST_BYTE;
    else if (wr_hbe) hblank_end_r <= reg_wdata;
  end

  // overflow takes the merged value, so bit 4 survives the protect bit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) overflow_r <= cvsp_pkg::RST_BYTE;
    else overflow_r <= overflow_nxt;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) sync_start_low_r <= cvsp_pkg::RST_BYTE;
    else if (wr_ss) sync_start_low_r <= reg_wdata;
  end

  // reset leaves the clear bit at 1 so the interrupt is live out of reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) sync_end_control_r <= cvsp_pkg::RST_SYNC_END_CTRL;
    else if (wr_sec) sync_end_control_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) display_end_low_r <= cvsp_pkg::RST_BYTE;
    else if (wr_de) display_end_low_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) row_pitch_r <= cvsp_pkg::RST_BYTE;
    else if (wr_rp) row_pitch_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) vblank_end_r <= cvsp_pkg::RST_BYTE;
    else if (wr_vbe) vblank_end_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) mode_control_r <= cvsp_pkg::RST_BYTE;
    else if (wr_mode) mode_control_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) extension_overflow_r <= cvsp_pkg::RST_BYTE;
    else if (wr_ext) extension_overflow_r <= reg_wdata;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scanline_r <= 10'h000;
      fetch_addr_r <= '0;
      vsync_r <= 1'b0;
      vblank_r <= 1'b0;
    end else if (line_start) begin
      scanline_r <= scanline_nxt;
      fetch_addr_r <= fetch_nxt;
      vsync_r <= vsync_nxt;
      vblank_r <= vblank_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending_r <= 1'b0;
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      reg_rvalid_r <= reg_rd;
      if (reg_rd) reg_rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;
  assign feature_status_reg = {pending_r, 7'h00};
  assign scanline = scanline_r;
  assign vsync = vsync_r;
  assign vblank = vblank_r;
  assign display_active = !vblank_r;
  assign fetch_addr = fetch_addr_r;
  assign refresh_count = sync_end_control_r[cvsp_pkg::SEC_REFRESH_BIT] ?
    cvsp_pkg::REFRESH_HIGH : cvsp_pkg::REFRESH_LOW;
  assign host_interrupt_pin = pending_r && irq_clr_n &&
    !sync_end_control_r[cvsp_pkg::SEC_IRQ_DIS_BIT];
endmodule : cvsp_vsync_pitch

// file: shared/cvsp_pkg.sv
// constants for the vertical sync, display end and row pitch block
package cvsp_pkg;
  // register indexes on the indexed port
  localparam logic [7:0] IDX_HBLANK_END = 8'h03;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_SYNC_START = 8'h10;
  localparam logic [7:0] IDX_SYNC_END_CTRL = 8'h11;
  localparam logic [7:0] IDX_DISP_END_LOW = 8'h12;
  localparam logic [7:0] IDX_ROW_PITCH = 8'h13;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h17;
  localparam logic [7:0] IDX_EXT_OVERFLOW = 8'h1b;
  localparam logic [7:0] IDX_PROTECT_LAST = 8'h07;
  // sync-end control fields
  localparam int SEC_PROTECT_BIT = 7;
  localparam int SEC_REFRESH_BIT = 6;
  localparam int SEC_IRQ_DIS_BIT = 5;
  localparam int SEC_IRQ_CLR_BIT = 4;
  localparam int SEC_END_MSB = 3;
  // other fields
  localparam int HBE_READ_EN_BIT = 7;
  localparam int OVF_ALWAYS_BIT = 4;
  localparam int OVF_SS9_BIT = 7;
  localparam int OVF_SS8_BIT = 2;
  localparam int OVF_DE9_BIT = 6;
  localparam int OVF_DE8_BIT = 1;
  localparam int EXT_PITCH8_BIT = 4;
  localparam int MODE_BYTE_WORD_BIT = 6;
  localparam int FEATURE_STATUS_REG_PENDING_BIT = 7;
  // refresh counts per scanline and the sync width limit
  localparam logic [2:0] REFRESH_LOW = 3'h3;
  localparam logic [2:0] REFRESH_HIGH = 3'h5;
  localparam int SYNC_WIDTH_MAX = 15;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SYNC_END_CTRL = 8'h10;
endpackage : cvsp_pkg

// file: test/cvsp_chk.sv
// port-level assertions for the vertical sync and pitch block
`timescale 1ns/1ps
module cvsp_chk #(
  parameter int ADDR_W = 19
) (
  // block inputs
  input wire logic mclk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic line_start,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [9:0] vertical_total,
  input wire logic [ADDR_W-1:0] screen_start,
  // block outputs
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] feature_status_reg,
  input wire logic reg_rvalid,
  input wire logic vsync,
  input wire logic display_active,
  input wire logic vblank,
  input wire logic host_interrupt_pin,
  input wire logic [9:0] scanline,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic [2:0] refresh_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire sec_wr = reg_wr && (reg_index == cvsp_pkg::IDX_SYNC_END_CTRL);
  wire [2:0] refresh_exp = reg_wdata[cvsp_pkg::SEC_REFRESH_BIT] ?
    cvsp_pkg::REFRESH_HIGH : cvsp_pkg::REFRESH_LOW;
  wire dis_wr = sec_wr && reg_wdata[cvsp_pkg::SEC_IRQ_DIS_BIT];
  wire clr_wr = sec_wr && !reg_wdata[cvsp_pkg::SEC_IRQ_CLR_BIT];
  wire at_total = line_start && scanline == vertical_total;
  wire mid_frame = line_start && scanline != vertical_total;
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_rquiet; !reg_rd |=> !reg_rvalid; endproperty
  a_rquiet: assert property (p_rquiet) else $error("stray read valid");
  property p_rdhold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  property p_refresh; sec_wr |=> refresh_count == $past(refresh_exp); endproperty
  a_refresh: assert property (p_refresh) else $error("refresh count wrong");
  property p_dis; dis_wr |=> !host_interrupt_pin; endproperty
  a_dis: assert property (p_dis) else $error("pin active while disabled");
  // pending is a register, so it falls one edge after the pin
  property p_clr; clr_wr |=> !host_interrupt_pin ##1 !feature_status_reg[7]; endproperty
  a_clr: assert property (p_clr) else $error("pending not cleared");
  property p_pin; host_interrupt_pin |-> feature_status_reg[7]; endproperty
  a_pin: assert property (p_pin) else $error("pin without pending");
  property p_act; display_active != vblank; endproperty
  a_act: assert property (p_act) else $error("active equals blank");
  property p_wrap;
    at_total |=> scanline == 10'h000 && fetch_addr == $past(screen_start);
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame wrap wrong");
  property p_step; mid_frame |=> scanline == $past(scanline) + 10'h001; endproperty
  a_step: assert property (p_step) else $error("scanline step wrong");
  property p_hold;
    !line_start |=> $stable(scanline) && $stable(fetch_addr) && $stable(vsync);
  endproperty
  a_hold: assert property (p_hold) else $error("timing moved without line");
endmodule : cvsp_chk
bind cvsp_vsync_pitch cvsp_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .line_start(line_start), .reg_index(reg_index),
  .reg_wdata(reg_wdata), .vertical_total(vertical_total), .screen_start(screen_start),
  .reg_rdata(reg_rdata), .feature_status_reg(feature_status_reg), .reg_rvalid(reg_rvalid),
  .vsync(vsync), .display_active(display_active), .vblank(vblank),
  .host_interrupt_pin(host_interrupt_pin), .scanline(scanline), .fetch_addr(fetch_addr),
  .refresh_count(refresh_count));

// file: test/cvsp_irq_host.sv
// host interrupt input model: counts interrupt assertions
`timescale 1ns/1ps
module cvsp_irq_host (
  input wire logic mclk,
  input wire logic reset,
  input wire logic host_interrupt_pin,
  output logic [7:0] irq_count
);
  logic pin_r;
  // edge count, so a level held across many lines is one interrupt
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_r <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      pin_r <= host_interrupt_pin;
      if (host_interrupt_pin && !pin_r) irq_count <= irq_count + 8'h01;
    end
  end
endmodule : cvsp_irq_host

// file: test/testbench.sv
// self-checking bench for the vertical sync, display end and pitch block
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, line_start = 1'b0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00;
  logic [9:0] vertical_total = 10'h014;
  logic [18:0] screen_start = 19'h00100;
  logic [7:0] reg_rdata, feature_status_reg, irq_count;
  logic reg_rvalid, vsync, display_active, vblank, host_interrupt_pin;
  logic [9:0] scanline;
  logic [18:0] fetch_addr;
  logic [2:0] refresh_count;
  int errors = 0;
  int checks = 0;
  always #50 mclk = ~mclk;
  cvsp_vsync_pitch #(.ADDR_W(19)) u_dut (.mclk(mclk), .reset(reset), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .feature_status_reg(feature_status_reg), .line_start(line_start),
    .vertical_total(vertical_total), .screen_start(screen_start), .scanline(scanline),
    .vsync(vsync), .display_active(display_active), .vblank(vblank), .fetch_addr(fetch_addr),
    .refresh_count(refresh_count), .host_interrupt_pin(host_interrupt_pin));
  cvsp_irq_host u_host (.mclk(mclk), .reset(reset), .host_interrupt_pin(host_interrupt_pin),
    .irq_count(irq_count));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk) {reg_index, reg_wdata, reg_wr} <= {idx, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
    @(negedge mclk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge mclk) {reg_index, reg_rd} <= {idx, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    @(negedge mclk) chk(reg_rvalid, 1);
    chk(reg_rdata, exp);
  endtask : rd_chk
  task automatic t_access;
    rd_chk(8'h11, 8'h00);
    wr(8'h03, 8'h80);
    rd_chk(8'h11, 8'h10);
    wr(8'h03, 8'h00);
    rd_chk(8'h11, 8'h00);
    wr(8'h11, 8'h50);
    chk(refresh_count, 3'h5);
    wr(8'h11, 8'h90);
    chk(refresh_count, 3'h3);
    wr(8'h07, 8'h52);
    rd_chk(8'h07, 8'h10);
    wr(8'h03, 8'h80);
    wr(8'h11, 8'h10);
    rd_chk(8'h03, 8'h00);
  endtask : t_access
  task automatic t_frame;
    logic [9:0] s = 10'h000;
    logic [9:0] ss = 10'h004;
    logic [9:0] de = 10'h008;
    logic [18:0] e = 19'h00000;
    logic v = 1'b0;
    logic b = 1'b0;
    logic p = 1'b0;
    logic m = 1'b1;
    // sync 4..18 is a 15-line pulse and ends before total 20
    wr(8'h10, 8'h04);
    wr(8'h12, 8'h08);
    wr(8'h13, 8'h05);
    wr(8'h16, 8'h10);
    wr(8'h1b, 8'h10);
    wr(8'h17, 8'h40);
    wr(8'h07, 8'h00);
    wr(8'h11, 8'h13);
    for (int i = 0; i < 42; i++) begin
      // second frame: word mode, upper field bits put sync and display end past total
      if (i == 21) begin
        wr(8'h17, 8'h00);
        wr(8'h07, 8'h46);
        m = 1'b0;
        ss = 10'h104;
        de = 10'h308;
      end
      @(posedge mclk) line_start <= 1'b1;
      @(posedge mclk) line_start <= 1'b0;
      s = (s == vertical_total) ? 10'h000 : s + 10'h001;
      e = (s == 10'h000) ? screen_start : e + (m ? 19'h00105 : 19'h0020a);
      v = (s == ss) ? 1'b1 : (s[3:0] == 4'h3) ? 1'b0 : v;
      b = (s[7:0] == 8'h10) ? 1'b0 : (s == de) ? 1'b1 : b;
      p = p | (s == de);
      @(negedge mclk) chk(scanline, s);
      chk(fetch_addr, e);
      chk(vsync, v);
      chk(vblank, b);
      chk(display_active, !b);
      chk(host_interrupt_pin, p);
    end
  endtask : t_frame
  task automatic t_irq;
    chk(feature_status_reg, 8'h80);
    wr(8'h11, 8'h33);
    chk(host_interrupt_pin, 1'b0);
    chk(feature_status_reg, 8'h80);
    wr(8'h11, 8'h13);
    chk(host_interrupt_pin, 1'b1);
    wr(8'h11, 8'h03);
    chk(host_interrupt_pin, 1'b0);
    // pending is registered, so it drops one edge after the clear bit lands
    @(negedge mclk);
    chk(feature_status_reg, 8'h00);
    wr(8'h11, 8'h13);
    chk(host_interrupt_pin, 1'b0);
    chk(feature_status_reg, 8'h00);
    chk(irq_count, 8'h02);
  endtask : t_irq
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_access();
    t_frame();
    t_irq();
    complete_run();
  end
endmodule : testbench
